// *** core/reset_distribution_sequencer.sv ***
// Gathers reset causes and drives the core and bus reset lines.
// Assumes same-clock causes from clocked logic; supply causes, pins
// and mode pins arrive asynchronously.
`timescale 1ns/1ps
`default_nettype none
module reset_distribution_sequencer #(
   parameter int STRETCH_CYCLES = rst_seq_pkg::STRETCH_CYCLES
) (
   // Clock and block reset
   input  wire logic MCLK,
   input  wire logic SYS_RST,
   // Supply causes, asynchronous
   input  wire logic POWER_ON_CAUSE,
   input  wire logic LOW_VOLTAGE_CAUSE,
   // Device pins, asynchronous
   input  wire logic EXTERNAL_RESET_PIN_N,
   input  wire logic DEBUG_RESET_PIN_N,
   input  wire logic MODE_SELECT_PIN_0,
   input  wire logic MODE_SELECT_PIN_1,
   // Causes from same-clock logic
   input  wire logic DEEP_STANDBY_ENTRY_CAUSE,
   input  wire logic SOFT_WATCHDOG_CAUSE,
   input  wire logic HARD_WATCHDOG_CAUSE,
   input  wire logic CLOCK_FAILURE_CAUSE,
   input  wire logic BAD_FREQUENCY_CAUSE,
   input  wire logic SOFTWARE_REQUEST_CAUSE,
   // Soft bus reset controls, same clock
   input  wire logic PERIPH_BUS1_SOFT_RESET_CTL,
   input  wire logic PERIPH_BUS2_SOFT_RESET_CTL,
   // Core reset lines, active low
   output logic      CORE_POWER_ON_RESET_N,
   output logic      CORE_SYSTEM_RESET_N,
   output logic      CORE_DEBUG_RESET_N,
   // Bus reset lines, active high
   output logic      HIGH_SPEED_BUS_RESET,
   output logic      PERIPH_BUS0_RESET,
   output logic      PERIPH_BUS1_RESET,
   output logic      PERIPH_BUS2_RESET,
   // Latched operating mode
   output logic [rst_seq_pkg::MODE_W-1:0] OPERATING_MODE
);
   import rst_seq_pkg::*;

   logic [PIN_W-1:0]  pin_raw;
   logic [PIN_W-1:0]  pin_s1_q;
   logic [PIN_W-1:0]  pin_s2_q;
   logic [PIN_W-1:0]  pin_s3_q;
   logic [PIN_W-1:0]  pin_f_q;
   logic [MODE_W-1:0] mode_pins;
   cause_vec_t        cause_now;
   cause_vec_t        cause_any;
   cause_vec_t        issued;
   cause_vec_t        cap_q;
   cause_vec_t        cap_d;
   logic              mode_trig_q;
   logic              mode_trig_d;
   logic              hard_async;
   logic              por_on;
   logic              sys_on;
   logic              dbg_on;

   rst_line_if por_l ();
   rst_line_if sys_l ();
   rst_line_if dbg_l ();

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (SYS_RST);

   // Supply faults bypass the clock; the clock may not be running yet
   assign hard_async = POWER_ON_CAUSE | LOW_VOLTAGE_CAUSE;

   assign pin_raw = {MODE_SELECT_PIN_1, MODE_SELECT_PIN_0,
                     DEBUG_RESET_PIN_N, EXTERNAL_RESET_PIN_N,
                     LOW_VOLTAGE_CAUSE, POWER_ON_CAUSE};

   // Three-stage synchroniser for every asynchronous input
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         pin_s1_q <= PIN_RESET;
         pin_s2_q <= PIN_RESET;
         pin_s3_q <= PIN_RESET;
      end else begin
         pin_s1_q <= pin_raw;
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
      end
   end

   // A change counts only once stages two and three agree
   always_ff @(posedge MCLK) begin
      if (SYS_RST) pin_f_q <= PIN_RESET;
      else pin_f_q <= (pin_s2_q & pin_s3_q) | (pin_f_q & (pin_s2_q | pin_s3_q));
   end

   assign mode_pins = {pin_f_q[P_MODE1], pin_f_q[P_MODE0]};

   // Present causes, one bit each, all active high
   always_comb begin
      cause_now              = CAUSE_RESET;
      cause_now[C_POWER_ON]  = pin_f_q[P_POWER_ON];
      cause_now[C_LOW_VOLT]  = pin_f_q[P_LOW_VOLT];
      cause_now[C_DEEP_STBY] = DEEP_STANDBY_ENTRY_CAUSE;
      cause_now[C_EXT_PIN]   = !pin_f_q[P_EXT_N];
      cause_now[C_SOFT_WDG]  = SOFT_WATCHDOG_CAUSE;
      cause_now[C_HARD_WDG]  = HARD_WATCHDOG_CAUSE;
      cause_now[C_CLK_FAIL]  = CLOCK_FAILURE_CAUSE;
      cause_now[C_BAD_FREQ]  = BAD_FREQUENCY_CAUSE;
      cause_now[C_SW_REQ]    = SOFTWARE_REQUEST_CAUSE;
      cause_now[C_DBG_PIN]   = !pin_f_q[P_DBG_N];
   end

   // Which causes have already reached an asserted line
   always_comb begin
      issued            = {CAUSE_W{sys_l.active}};
      issued[C_DBG_PIN] = dbg_l.active;
   end

   // Capture: a bit drops only once issued and gone; a new event wins
   always_comb begin
      cap_d = (cap_q & ~(issued & ~cause_now)) | cause_now;
   end

   always_ff @(posedge MCLK) begin
      if (SYS_RST) cap_q <= CAUSE_RESET;
      else cap_q <= cap_d;
   end

   assign cause_any = cause_now | cap_q;

   // Each line sees only its own set of causes
   assign por_l.req = |(cause_any & POR_MASK);
   assign sys_l.req = |(cause_any & SYS_MASK);
   assign dbg_l.req = |(cause_any & DBG_MASK);

   // Hold and stretch per core line
   reset_line_stretcher #(
      .STRETCH_CYCLES (STRETCH_CYCLES)
   ) u_por_line (
      .clk (MCLK),
      .rst (SYS_RST),
      .lnk (por_l)
   );

   reset_line_stretcher #(
      .STRETCH_CYCLES (STRETCH_CYCLES)
   ) u_sys_line (
      .clk (MCLK),
      .rst (SYS_RST),
      .lnk (sys_l)
   );

   reset_line_stretcher #(
      .STRETCH_CYCLES (STRETCH_CYCLES)
   ) u_dbg_line (
      .clk (MCLK),
      .rst (SYS_RST),
      .lnk (dbg_l)
   );

   // A request asserts at once; release waits for the stretch
   assign por_on = por_l.req || por_l.active;
   assign sys_on = sys_l.req || sys_l.active;
   assign dbg_on = dbg_l.req || dbg_l.active;

   // Core lines: async assert on supply faults, clocked release
   always_ff @(posedge MCLK or posedge hard_async) begin
      if (hard_async) begin
         CORE_POWER_ON_RESET_N <= CORE_N_ASSERTED;
         CORE_SYSTEM_RESET_N   <= CORE_N_ASSERTED;
         CORE_DEBUG_RESET_N    <= CORE_N_ASSERTED;
      end else if (SYS_RST) begin
         CORE_POWER_ON_RESET_N <= CORE_N_ASSERTED;
         CORE_SYSTEM_RESET_N   <= CORE_N_ASSERTED;
         CORE_DEBUG_RESET_N    <= CORE_N_ASSERTED;
      end else begin
         CORE_POWER_ON_RESET_N <= !por_on;
         CORE_SYSTEM_RESET_N   <= !sys_on;
         CORE_DEBUG_RESET_N    <= !dbg_on;
      end
   end

   // Bus lines: same timing as the system line, active high
   always_ff @(posedge MCLK or posedge hard_async) begin
      if (hard_async) begin
         HIGH_SPEED_BUS_RESET <= BUS_ASSERTED;
         PERIPH_BUS0_RESET    <= BUS_ASSERTED;
         PERIPH_BUS1_RESET    <= BUS_ASSERTED;
         PERIPH_BUS2_RESET    <= BUS_ASSERTED;
      end else if (SYS_RST) begin
         HIGH_SPEED_BUS_RESET <= BUS_ASSERTED;
         PERIPH_BUS0_RESET    <= BUS_ASSERTED;
         PERIPH_BUS1_RESET    <= BUS_ASSERTED;
         PERIPH_BUS2_RESET    <= BUS_ASSERTED;
      end else begin
         HIGH_SPEED_BUS_RESET <= sys_on;
         PERIPH_BUS0_RESET    <= sys_on;
         // Soft controls act alone and are not stretched
         PERIPH_BUS1_RESET    <= sys_on || PERIPH_BUS1_SOFT_RESET_CTL;
         PERIPH_BUS2_RESET    <= sys_on || PERIPH_BUS2_SOFT_RESET_CTL;
      end
   end

   // Remember whether this reset must re-read the mode pins
   always_comb begin
      mode_trig_d = (mode_trig_q && !sys_l.done) || (|(cause_any & MODE_MASK));
   end

   // Block reset counts as power-up, so the first release samples
   always_ff @(posedge MCLK) begin
      if (SYS_RST) mode_trig_q <= MODE_TRIG_RESET;
      else mode_trig_q <= mode_trig_d;
   end

   // Mode latched on the release edge of the system line
   always_ff @(posedge MCLK) begin
      if (SYS_RST) OPERATING_MODE <= MODE_RESET;
      else if (sys_l.done && mode_trig_q) OPERATING_MODE <= mode_pins;
   end

   sequence s_mode_release;
      sys_l.done && mode_trig_q;
   endsequence

   sequence s_sys_idle;
      CORE_SYSTEM_RESET_N && !sys_l.req;
   endsequence

   chk_por_deep_stby: assert property (
      cause_now[C_DEEP_STBY] |-> ##[0:1] !CORE_POWER_ON_RESET_N)
      else $error("deep standby did not assert power-on line");
   chk_por_only_own: assert property (
      (CORE_POWER_ON_RESET_N && !por_l.req) |=>
      (CORE_POWER_ON_RESET_N || hard_async))
      else $error("power-on line asserted by a foreign cause");
   chk_sys_any_cause: assert property (
      (|(cause_now & SYS_MASK)) |-> ##[0:1] !CORE_SYSTEM_RESET_N)
      else $error("system line missed a cause");
   chk_dbg_pin_line: assert property (
      cause_now[C_DBG_PIN] |-> ##[0:1] !CORE_DEBUG_RESET_N)
      else $error("debug pin did not assert debug line");
   chk_dbg_only_own: assert property (
      (CORE_DEBUG_RESET_N && !dbg_l.req) |=>
      (CORE_DEBUG_RESET_N || hard_async))
      else $error("debug line asserted by a foreign cause");
   chk_bus_follow_sys: assert property (
      (HIGH_SPEED_BUS_RESET == !CORE_SYSTEM_RESET_N) &&
      (PERIPH_BUS0_RESET == HIGH_SPEED_BUS_RESET))
      else $error("bus reset differs from system line");
   chk_soft_bus1: assert property (
      PERIPH_BUS1_SOFT_RESET_CTL |=> PERIPH_BUS1_RESET)
      else $error("bus 1 soft control ignored");
   chk_soft_bus2: assert property (
      (s_sys_idle and !PERIPH_BUS2_SOFT_RESET_CTL) |=>
      (!PERIPH_BUS2_RESET || hard_async || sys_l.req))
      else $error("bus 2 reset without cause");
   chk_capture_pulse: assert property (
      $rose(cause_now[C_SOFT_WDG]) |=> !CORE_SYSTEM_RESET_N [*3])
      else $error("short cause not held");
   chk_mode_sample: assert property (
      s_mode_release |=> OPERATING_MODE == $past(mode_pins))
      else $error("mode pins not latched on release");
   chk_mode_keep: assert property (
      !(sys_l.done && mode_trig_q) |=> $stable(OPERATING_MODE))
      else $error("mode changed without a mode cause");
   chk_clean_release: assert property (
      $rose(CORE_SYSTEM_RESET_N) |-> $past(sys_l.done))
      else $error("system line left reset off sequence");

   // Cross-line checks; soft buses may only ever add resets, never drop one
   // Peripheral bus 1 never runs while the core is held
   chk_bus1_sys: assert property (
      !CORE_SYSTEM_RESET_N |-> PERIPH_BUS1_RESET)
      else $error("bus 1 running during system reset");
   // Peripheral bus 2 never runs while the core is held
   chk_bus2_sys: assert property (
      !CORE_SYSTEM_RESET_N |-> PERIPH_BUS2_RESET)
      else $error("bus 2 running during system reset");
   // Bus 2 soft control takes effect on the next edge
   chk_soft_bus2_set: assert property (
      PERIPH_BUS2_SOFT_RESET_CTL |=> PERIPH_BUS2_RESET)
      else $error("bus 2 soft control ignored");
   // The synchronised reset pin reaches the system line
   chk_ext_pin_sys: assert property (
      cause_now[C_EXT_PIN] |-> ##[0:1] !CORE_SYSTEM_RESET_N)
      else $error("reset pin did not assert system line");
   // The debug pin alone must leave the system line running
   chk_sys_only_own: assert property (
      s_sys_idle |=> (CORE_SYSTEM_RESET_N || hard_async))
      else $error("system line asserted by a foreign cause");
   // Power-on cause, once synchronised, still holds the power-on line
   chk_por_supply: assert property (
      cause_now[C_POWER_ON] |-> ##[0:1] !CORE_POWER_ON_RESET_N)
      else $error("power-on cause lost on power-on line");
   // Low voltage also clears the debug port
   chk_dbg_low_volt: assert property (
      cause_now[C_LOW_VOLT] |-> ##[0:1] !CORE_DEBUG_RESET_N)
      else $error("low voltage did not assert debug line");
   // Mode moves only on a system line release
   chk_mode_on_release: assert property (
      $changed(OPERATING_MODE) |-> $past(sys_l.done))
      else $error("mode changed outside a release");

endmodule
`default_nettype wire

// *** core/reset_line_stretcher.sv ***
// One reset line's hold and stretch sequence.
// Assumes a synchronous active-high reset and a same-clock request.
`timescale 1ns/1ps
`default_nettype none
module reset_line_stretcher #(
   parameter int STRETCH_CYCLES = rst_seq_pkg::STRETCH_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Link to the distributor
   rst_line_if.line lnk
);
   import rst_seq_pkg::*;

   localparam int CW = (STRETCH_CYCLES > 1) ? $clog2(STRETCH_CYCLES) : 1;
   localparam logic [CW-1:0] LAST = CW'(STRETCH_CYCLES - 1);

   line_state_t     state_q;
   line_state_t     state_d;
   logic [CW-1:0]   cnt_q;
   logic            done_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // A returning request during the stretch restarts the hold
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_RUN: begin
            if (lnk.req) state_d = ST_HOLD;
         end
         ST_HOLD: begin
            if (!lnk.req) state_d = ST_EXTEND;
         end
         ST_EXTEND: begin
            if (lnk.req) state_d = ST_HOLD;
            else if (cnt_q == LAST) state_d = ST_RUN;
         end
         default: state_d = ST_HOLD;
      endcase
   end

   // Sequence state; reset leaves the line held so it stretches out
   always_ff @(posedge clk) begin
      if (rst) state_q <= LINE_RESET_STATE;
      else state_q <= state_d;
   end

   // Stretch counter, only runs while extending
   always_ff @(posedge clk) begin
      if (rst || state_q != ST_EXTEND) cnt_q <= '0;
      else cnt_q <= cnt_q + 1'h1;
   end

   // One-cycle release marker
   always_ff @(posedge clk) begin
      if (rst) done_q <= 1'h0;
      else done_q <= (state_q == ST_EXTEND) && (state_d == ST_RUN);
   end

   assign lnk.active = (state_q != ST_RUN);
   assign lnk.done   = done_q;

   sequence s_cause_gone;
      (state_q == ST_HOLD) && !lnk.req;
   endsequence

   chk_hold_on_req: assert property (lnk.req |=> lnk.active)
      else $error("line not held after request");
   chk_stretch_start: assert property (s_cause_gone |=> state_q == ST_EXTEND)
      else $error("stretch did not start when cause left");
   chk_stretch_full: assert property (done_q |-> $past(cnt_q) == LAST)
      else $error("line released before full stretch");

endmodule
`default_nettype wire

// *** core/rst_line_if.sv ***
// Request and status between the distributor and one line stretcher.
// Assumes both ends sit on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface rst_line_if;
   logic req;
   logic active;
   logic done;

   modport ctl (output req, input active, input done);
   modport line (input req, output active, output done);
endinterface
`default_nettype wire

// *** core/rst_seq_pkg.sv ***
// Constants, types and state codes for the reset distribution sequencer.
// Assumes one 40 MHz system clock; all widths and offsets live here.
package rst_seq_pkg;

   // Cause vector layout
   localparam int CAUSE_W     = 10;
   localparam int C_POWER_ON  = 0;
   localparam int C_LOW_VOLT  = 1;
   localparam int C_DEEP_STBY = 2;
   localparam int C_EXT_PIN   = 3;
   localparam int C_SOFT_WDG  = 4;
   localparam int C_HARD_WDG  = 5;
   localparam int C_CLK_FAIL  = 6;
   localparam int C_BAD_FREQ  = 7;
   localparam int C_SW_REQ    = 8;
   localparam int C_DBG_PIN   = 9;

   typedef logic [CAUSE_W-1:0] cause_vec_t;

   // Which causes drive which line
   localparam cause_vec_t POR_MASK    = 10'h007;
   localparam cause_vec_t SYS_MASK    = 10'h1FF;
   localparam cause_vec_t DBG_MASK    = 10'h207;
   localparam cause_vec_t MODE_MASK   = 10'h00B;
   localparam cause_vec_t CAUSE_RESET = 10'h000;

   // Synchronised pin vector layout
   localparam int PIN_W      = 6;
   localparam int P_POWER_ON = 0;
   localparam int P_LOW_VOLT = 1;
   localparam int P_EXT_N    = 2;
   localparam int P_DBG_N    = 3;
   localparam int P_MODE0    = 4;
   localparam int P_MODE1    = 5;
   localparam logic [PIN_W-1:0] PIN_RESET = 6'h0C;

   // Operating mode and reset levels
   localparam int MODE_W = 2;
   localparam logic [MODE_W-1:0] MODE_RESET = 2'h0;
   localparam logic MODE_TRIG_RESET = 1'h1;
   localparam logic CORE_N_ASSERTED = 1'h0;
   localparam logic BUS_ASSERTED    = 1'h1;

   // Stretch after the last cause: oscillator settling, least time
   localparam int STRETCH_TIME_NS = 10000;
   localparam int CLK_PERIOD_PS   = 25000;
   localparam int STRETCH_CYCLES  =
      (STRETCH_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   // Per-line sequencing states
   typedef enum logic [1:0] {ST_RUN, ST_HOLD, ST_EXTEND} line_state_t;
   localparam line_state_t LINE_RESET_STATE = ST_HOLD;

endpackage

// *** test/core_bus_partner.sv ***
// Processor core and bus domain stand-in on the far side of the resets.
// Assumes the same system clock and an active-low system reset.
`timescale 1ns/1ps
`default_nettype none
module core_bus_partner (
   // Clock and incoming core reset
   input  wire logic clk,
   input  wire logic sys_rst_n,
   // Set once the reset vector has been fetched
   output logic      fetched
);
   logic [1:0] wait_q;

   // Vector fetch three cycles after release; reset may drop without a clock
   always_ff @(posedge clk or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         wait_q  <= 2'h0;
         fetched <= 1'b0;
      end else if (wait_q != 2'h2) begin
         wait_q <= wait_q + 2'h1;
      end else begin
         fetched <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// *** test/reset_distribution_sequencer_tb_top.sv ***
// Self-checking bench for the reset distribution sequencer.
// Assumes the package and design files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module reset_distribution_sequencer_tb_top;
   import rst_seq_pkg::*;
   localparam int STR = 4;
   logic       mclk, sys_rst, pwr, lowv, ext_n, dbg_n, md0, md1, dstby;
   logic       swdg, hwdg, cfail, bfreq, swreq, ctl1, ctl2;
   logic       por_n, sys_n, dbgr_n, hsb, pb0, pb1, pb2, fetched;
   logic [1:0] mode;
   logic [1:0] mode_exp;
   int         n_errors = 0;
   int         check_count = 0;

   reset_distribution_sequencer #(.STRETCH_CYCLES(STR)) dut_u (
      .MCLK(mclk), .SYS_RST(sys_rst), .POWER_ON_CAUSE(pwr), .LOW_VOLTAGE_CAUSE(lowv),
      .EXTERNAL_RESET_PIN_N(ext_n), .DEBUG_RESET_PIN_N(dbg_n), .MODE_SELECT_PIN_0(md0),
      .MODE_SELECT_PIN_1(md1), .DEEP_STANDBY_ENTRY_CAUSE(dstby), .SOFT_WATCHDOG_CAUSE(swdg),
      .HARD_WATCHDOG_CAUSE(hwdg), .CLOCK_FAILURE_CAUSE(cfail), .BAD_FREQUENCY_CAUSE(bfreq),
      .SOFTWARE_REQUEST_CAUSE(swreq), .PERIPH_BUS1_SOFT_RESET_CTL(ctl1),
      .PERIPH_BUS2_SOFT_RESET_CTL(ctl2), .CORE_POWER_ON_RESET_N(por_n),
      .CORE_SYSTEM_RESET_N(sys_n), .CORE_DEBUG_RESET_N(dbgr_n), .HIGH_SPEED_BUS_RESET(hsb),
      .PERIPH_BUS0_RESET(pb0), .PERIPH_BUS1_RESET(pb1), .PERIPH_BUS2_RESET(pb2),
      .OPERATING_MODE(mode));

   core_bus_partner core_u (.clk(mclk), .sys_rst_n(sys_n), .fetched(fetched));

   // 40 MHz system clock
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   task automatic check(string what, logic [1:0] exp, logic [1:0] got);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Pins are active low, every other cause active high
   task automatic drive(int i, logic v);
      case (i)
         C_POWER_ON:  pwr <= v;
         C_LOW_VOLT:  lowv <= v;
         C_EXT_PIN:   ext_n <= !v;
         C_DBG_PIN:   dbg_n <= !v;
         C_DEEP_STBY: dstby <= v;
         C_SOFT_WDG:  swdg <= v;
         C_HARD_WDG:  hwdg <= v;
         C_CLK_FAIL:  cfail <= v;
         C_BAD_FREQ:  bfreq <= v;
         default:     swreq <= v;
      endcase
   endtask

   // Bounded wait until the three core lines, hsb and pb0 have let go
   task automatic wait_idle(output int n);
      n = 0;
      while (!(por_n === 1'b1 && sys_n === 1'b1 && dbgr_n === 1'b1 && hsb === 1'b0
               && pb0 === 1'b0) && n < 60) begin
         @(posedge mclk);
         #1;
         n++;
      end
   endtask

   task automatic t_boot();
      int n;
      repeat (5) @(posedge mclk);
      sys_rst <= 1'b0;
      #1;
      check("lines in block reset", 2'h0, {por_n, sys_n});
      check("mode in block reset", MODE_RESET, mode);
      wait_idle(n);
      mode_exp = 2'h2;
      check("mode after power-up", mode_exp, mode);
      $display("boot test done");
   endtask

   task automatic t_soft();
      for (int b = 0; b < 2; b++) begin
         @(posedge mclk);
         ctl1 <= (b == 0);
         ctl2 <= (b == 1);
         repeat (2) @(posedge mclk);
         #1;
         check("soft bus resets", (b == 0) ? 2'h2 : 2'h1, {pb1, pb2});
         check("other lines untouched", 2'h0, {!sys_n, hsb});
         @(posedge mclk);
         ctl1 <= 1'b0;
         ctl2 <= 1'b0;
         repeat (2) @(posedge mclk);
         #1;
         check("soft bus resets let go", 2'h0, {pb1, pb2});
      end
      $display("soft control test done");
   endtask

   // A second cause inside the stretch must start the hold again
   task automatic t_restart();
      int n;
      @(posedge mclk);
      swdg <= 1'b1;
      @(posedge mclk);
      swdg <= 1'b0;
      repeat (2) @(posedge mclk);
      hwdg <= 1'b1;
      @(posedge mclk);
      hwdg <= 1'b0;
      repeat (STR + 1) @(posedge mclk);
      #1;
      check("stretch restarted", 2'h1, {sys_n, pb0});
      wait_idle(n);
      check("released after restart", 2'h1, n < 16);
      $display("restart test done");
   endtask

   task automatic t_cause(int i);
      int n;
      logic [1:0] newm;
      newm = mode_exp + 2'h1;
      @(posedge mclk);
      md0 <= newm[0];
      md1 <= newm[1];
      repeat (5) @(posedge mclk);
      drive(i, 1'b1);
      #1;
      if (i <= C_LOW_VOLT) begin
         check("supply cause without clock", 2'h0, {por_n, sys_n});
      end
      repeat (6) @(posedge mclk);
      #1;
      check("core power-on reset", !POR_MASK[i], por_n);
      check("core system reset", !SYS_MASK[i], sys_n);
      check("core debug reset", !DBG_MASK[i], dbgr_n);
      check("bus and bus0 resets", {2{SYS_MASK[i]}}, {hsb, pb0});
      check("bus1 and bus2 resets", {2{SYS_MASK[i]}}, {pb1, pb2});
      @(posedge mclk);
      drive(i, 1'b0);
      repeat (STR) @(posedge mclk);
      #1;
      check("reset held in stretch", 2'h1, !(por_n && sys_n && dbgr_n));
      wait_idle(n);
      check("released in time", 2'h1, n < 16);
      if (MODE_MASK[i]) begin
         mode_exp = newm;
      end
      check("operating mode", mode_exp, mode);
      repeat (4) @(posedge mclk);
      #1;
      check("core running after release", 2'h1, fetched);
      $display("cause %0d test done", i);
   endtask

   // Watchdog: the whole run needs well under 4000 cycles
   initial begin
      #100000;
      n_errors++;
      conclude();
   end

   // Main sequence; mode pins differ from the reset mode value
   initial begin
      {sys_rst, pwr, lowv, dstby, swdg, hwdg, cfail, bfreq, swreq, ctl1, ctl2} = 11'h400;
      ext_n = 1'b1;
      dbg_n = 1'b1;
      md0 = 1'b0;
      md1 = 1'b1;
      mode_exp = MODE_RESET;
      t_boot();
      t_soft();
      t_restart();
      for (int i = 0; i < CAUSE_W; i++) begin
         t_cause(i);
      end
      conclude();
   end
endmodule
`default_nettype wire
